/* File: sim/iod_host_model.sv */
// Purpose: Host bus master model facing the I/O board decoder
// Assumes: Requests are applied by the bench before a falling edge
// Notes:   A released bus inverts its address on every falling edge
module iod_host_model
(
	input  wire logic        clk,
	input  wire logic [15:0] req_addr,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	output logic [15:0]      addr,
	output logic             valid_address_qualifier,
	output logic             rd_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		addr = 16'h0000;
		valid_address_qualifier = 1'b0;
		rd_wr = 1'b1;
	end
	always @(negedge clk)
	begin
		valid_address_qualifier <= req_valid;
		addr <= req_valid ? req_addr : ~addr;
		rd_wr <= !(req_valid && req_write);
	end
endmodule

/* File: sim/tb_iod_decoder.sv */
// Purpose: Self-checking bench for the I/O board address decoder
// Assumes: Inputs change on falling edges only
// Notes:   Baud half-period set to 3 clocks, then 5 from the reset test on, to keep runs short
module tb_iod_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, req_valid, req_write;
	logic [7:0]  sense_switch, sense_data;
	logic [15:0] baud_div, req_addr, addr;
	logic        valid_address_qualifier, rd_wr, sense_data_oe, bus_enable_clk, baud_clk;
	logic        serial_select_lo_a, serial_select_hi_b, serial_select_low_n;
	logic        serial_register_select, par0_select, par1_select;
	logic        parallel_register_select_lo, parallel_register_select_hi;
	logic        sense_buf_en_n_0, sense_buf_en_n_1;
	int          fail_count, total_checks, n;
	logic [15:0] a;
	wire  [7:0]  sel_v = {serial_select_lo_a, serial_select_hi_b, serial_select_low_n,
		par0_select, par1_select, sense_buf_en_n_0, sense_buf_en_n_1, sense_data_oe};

	iod_host_model iod_host_model_inst (.clk(clk), .req_addr(req_addr), .req_valid(req_valid),
		.req_write(req_write), .addr(addr), .valid_address_qualifier(valid_address_qualifier),
		.rd_wr(rd_wr));
	iod_decoder iod_decoder_inst (.clk(clk), .rst(rst), .addr(addr),
		.valid_address_qualifier(valid_address_qualifier), .rd_wr(rd_wr),
		.sense_switch(sense_switch), .baud_div(baud_div),
		.serial_select_lo_a(serial_select_lo_a), .serial_select_hi_b(serial_select_hi_b),
		.serial_select_low_n(serial_select_low_n), .serial_register_select(serial_register_select),
		.par0_select(par0_select), .par1_select(par1_select),
		.parallel_register_select_lo(parallel_register_select_lo),
		.parallel_register_select_hi(parallel_register_select_hi),
		.sense_buf_en_n_0(sense_buf_en_n_0), .sense_buf_en_n_1(sense_buf_en_n_1),
		.sense_data(sense_data), .sense_data_oe(sense_data_oe),
		.bus_enable_clk(bus_enable_clk), .baud_clk(baud_clk));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic drive(input logic [15:0] ad, input logic v, input logic w);
		req_addr <= ad;
		req_valid <= v;
		req_write <= w;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	function automatic logic cur(input bit b);
		return b ? baud_clk : bus_enable_clk;
	endfunction
	// Length of one high phase, bounded
	task automatic run_high(input bit b, output int len);
		int g;
		g = 0;
		len = 0;
		while (cur(b) !== 1'b0 && g < 999) begin g++; @(negedge clk); end
		while (cur(b) !== 1'b1 && g < 999) begin g++; @(negedge clk); end
		while (cur(b) === 1'b1 && g < 999) begin g++; len++; @(negedge clk); end
		if (g >= 999)
		begin
			fail_count++;
			$display("Error at %0t: clock phase timed out", $time);
			test_done();
		end
	endtask
	task automatic t_serial;
		for (int i = 4; i < 8; i++)
		begin
			a = 16'hf000 + 16'(i);
			drive(a, 1'b1, 1'b0);
			chk(16'(sel_v), {8'h00, 1'b1, a[1], 6'h06});
			chk(16'(serial_register_select), 16'(a[0]));
		end
	endtask
	task automatic t_parallel;
		for (int i = 8; i < 16; i++)
		begin
			a = 16'hf000 + 16'(i);
			drive(a, 1'b1, 1'b0);
			chk(16'(sel_v), {8'h00, 3'h1, a[3:2] == 2'h2, a[3:2] == 2'h3, 3'h6});
			chk(16'({parallel_register_select_lo, parallel_register_select_hi}),
				16'({!a[0], a[1]}));
		end
	endtask
	task automatic t_sense;
		sense_switch <= 8'h5a;
		drive(16'hf003, 1'b1, 1'b1);
		chk(16'(sel_v), 16'h0020);
		chk(16'(sense_data), 16'h0000);
		drive(16'hf003, 1'b1, 1'b0);
		chk(16'(sel_v), 16'h0021);
		chk(16'(sense_data), 16'h005a);
		sense_switch <= 8'ha5;
		drive(16'hf003, 1'b1, 1'b0);
		drive(16'hf003, 1'b1, 1'b0);
		chk(16'(sense_data), 16'h00a5);
	endtask
	task automatic t_reset;
		drive(16'hf006, 1'b1, 1'b0);
		rst <= 1'b1;
		baud_div <= 16'h0005;
		repeat (3) @(negedge clk);
		chk(16'(sel_v), 16'h0026);
		chk(16'(sense_data), 16'h0000);
		rst <= 1'b0;
		@(negedge clk);
		chk(16'(sel_v), 16'h00c6);
	endtask
	task automatic t_refuse;
		logic [16:0] tbl [7] = '{17'h0f006, 17'h1e006, 17'h17006, 17'h0f00c, 17'h0f003,
			17'h1f002, 17'h1f013};
		foreach (tbl[i])
		begin
			drive(tbl[i][15:0], tbl[i][16], 1'b0);
			chk(16'(sel_v), 16'h0026);
		end
	endtask
	task automatic t_clocks;
		run_high(1'b0, n);
		chk(16'(n), 16'h0064);
		run_high(1'b1, n);
		chk(16'(n), baud_div);
	endtask

	initial
	begin
		rst = 1'b1;
		sense_switch = 8'h00;
		baud_div = 16'h0003;
		req_addr = 16'h0000;
		req_valid = 1'b0;
		req_write = 1'b0;
		fail_count = 0;
		total_checks = 0;
		repeat (16) @(negedge clk);
		chk(16'(sel_v), 16'h0026);
		rst <= 1'b0;
		t_serial();
		t_parallel();
		t_sense();
		t_refuse();
		t_reset();
		t_clocks();
		test_done();
	end
endmodule

/* File: verilog/iod_decoder.sv */
// Contract
// - With the qualifier high at the serial location, both high selects go high and the low one low.
// - No chip select asserts unless address bits 15 to 12 are all high and the qualifier is high.
// - The serial register select follows address bit zero without inversion.
// - The serial baud clock runs at sixteen times the chosen bit rate.
// - Each adapter enable receives the 500 kHz second-phase bus clock.
// - The two parallel adapters sit at the lower base and four bytes above it.
// - Parallel chip selects come from a decode of address bits three and two plus the page and mid-address decodes.
// - The parallel upper register select follows address bit one.
// - The parallel lower register select is the inverse of address bit zero.
// - The serial second high select is driven high when address bit one is high.
// - The serial low select goes low when address bit two is high.
// - With the qualifier high at the sense location, both sense buffer enables go low.
// - The sense buffer enable needs page, mid-address and low-address decodes all high.
// - A read of the sense location returns the eight sense switch bits.
//
// Purpose: Address decode, select generation and clocks for the I/O board
// Assumes: Address and qualifier come from logic on clk; switches are pins
// Notes:   Outputs are registered, so selects lag the address by one clock
module iod_decoder
	import iod_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] addr,
	input  wire logic        valid_address_qualifier,
	input  wire logic        rd_wr,
	input  wire logic [7:0]  sense_switch,
	input  wire logic [15:0] baud_div,
	output logic             serial_select_lo_a,
	output logic             serial_select_hi_b,
	output logic             serial_select_low_n,
	output logic             serial_register_select,
	output logic             par0_select,
	output logic             par1_select,
	output logic             parallel_register_select_lo,
	output logic             parallel_register_select_hi,
	output logic             sense_buf_en_n_0,
	output logic             sense_buf_en_n_1,
	output logic [7:0]       sense_data,
	output logic             sense_data_oe,
	output logic             bus_enable_clk,
	output logic             baud_clk
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
		input logic [15:0] mask);
		hit = ((a & mask) == (base & mask));
	endfunction

	wire page_hit   = valid_address_qualifier && (addr[15:12] == PAGE_NIBBLE);
	wire serial_hit = page_hit && hit(addr, SERIAL_ADDR, SERIAL_MASK);
	wire par_any    = page_hit && (addr[11:4] == PAR0_ADDR[11:4]) && addr[3];
	wire par0_hit   = par_any && (addr[3:2] == PAR0_SEL);
	wire par1_hit   = par_any && (addr[3:2] == PAR1_SEL);
	wire mid_hit    = (addr[11:4] == SENSE_ADDR[11:4]);
	wire low_hit    = (addr[3:0] == SENSE_ADDR[3:0]);
	wire sense_hit  = page_hit && mid_hit && low_hit;
	wire read_cycle = rd_wr;

	// ------------------------------------------------------------
	// Sense switch synchroniser
	// ------------------------------------------------------------
	logic [7:0] sw_s1_ff;
	logic [7:0] sw_s2_ff;
	logic [7:0] sw_s3_ff;
	logic [7:0] sw_val_ff;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sw_s1_ff  <= ZERO8;
			sw_s2_ff  <= ZERO8;
			sw_s3_ff  <= ZERO8;
			sw_val_ff <= ZERO8;
		end
		else
		begin
			sw_s1_ff <= sense_switch;
			sw_s2_ff <= sw_s1_ff;
			sw_s3_ff <= sw_s2_ff;
			if (sw_s2_ff == sw_s3_ff)
				sw_val_ff <= sw_s3_ff;
		end
	end

	// ------------------------------------------------------------
	// Registered select outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			serial_select_lo_a          <= 1'b0;
			serial_select_hi_b          <= 1'b0;
			serial_select_low_n         <= 1'b1;
			serial_register_select      <= 1'b0;
			par0_select                 <= 1'b0;
			par1_select                 <= 1'b0;
			parallel_register_select_lo <= 1'b0;
			parallel_register_select_hi <= 1'b0;
			sense_buf_en_n_0            <= 1'b1;
			sense_buf_en_n_1            <= 1'b1;
			sense_data                  <= ZERO8;
			sense_data_oe               <= 1'b0;
		end
		else
		begin
			serial_select_lo_a     <= serial_hit;
			serial_select_hi_b     <= serial_hit && addr[1];
			serial_select_low_n    <= !(serial_hit && addr[2]);
			serial_register_select <= addr[0];
			par0_select            <= par0_hit;
			par1_select            <= par1_hit;
			parallel_register_select_lo <= !addr[0];
			parallel_register_select_hi <= addr[1];
			sense_buf_en_n_0       <= !sense_hit;
			sense_buf_en_n_1       <= !sense_hit;
			sense_data             <= (sense_hit && read_cycle) ? sw_val_ff : ZERO8;
			sense_data_oe          <= sense_hit && read_cycle;
		end
	end

	// ------------------------------------------------------------
	// Bus clock and baud clock
	// ------------------------------------------------------------
	logic [7:0]  bus_cnt_ff;
	logic [15:0] baud_cnt_ff;
	wire  [15:0] baud_lim = (baud_div == 16'h0000) ? BAUD_DIV_DEFAULT : baud_div;
	wire         bus_wrap = (bus_cnt_ff == BUS_HALF_LAST);
	wire         baud_wrap = (baud_cnt_ff >= baud_lim - ONE16);
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bus_cnt_ff     <= ZERO8;
			bus_enable_clk <= 1'b0;
			baud_cnt_ff    <= 16'h0000;
			baud_clk       <= 1'b0;
		end
		else
		begin
			bus_cnt_ff     <= bus_wrap ? ZERO8 : bus_cnt_ff + 8'h01;
			bus_enable_clk <= bus_wrap ? !bus_enable_clk : bus_enable_clk;
			baud_cnt_ff    <= baud_wrap ? 16'h0000 : baud_cnt_ff + ONE16;
			baud_clk       <= baud_wrap ? !baud_clk : baud_clk;
		end
	end

	// ------------------------------------------------------------
	// Clock phase observers for checks
	// ------------------------------------------------------------
	logic        bus_prev_ff;
	logic        bus_seen_ff;
	logic [7:0]  bus_len_ff;
	logic        baud_prev_ff;
	logic        baud_seen_ff;
	logic [15:0] baud_len_ff;
	logic [15:0] baud_div_ff;
	wire         bus_edge     = (bus_enable_clk != bus_prev_ff);
	wire         baud_edge    = (baud_clk != baud_prev_ff);
	wire         div_moved    = (baud_div != baud_div_ff);
	wire  [15:0] baud_lim_ref = (baud_div_ff == 16'h0000) ? BAUD_DIV_DEFAULT : baud_div_ff;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bus_prev_ff  <= 1'b0;
			bus_seen_ff  <= 1'b0;
			bus_len_ff   <= ZERO8;
			baud_prev_ff <= 1'b0;
			baud_seen_ff <= 1'b0;
			baud_len_ff  <= 16'h0000;
			baud_div_ff  <= 16'h0000;
		end
		else
		begin
			bus_prev_ff  <= bus_enable_clk;
			bus_seen_ff  <= bus_seen_ff || bus_edge;
			bus_len_ff   <= bus_edge ? ZERO8 : bus_len_ff + 8'h01;
			baud_prev_ff <= baud_clk;
			baud_div_ff  <= baud_div;
			baud_seen_ff <= !div_moved && (baud_seen_ff || baud_edge);
			baud_len_ff  <= baud_edge ? 16'h0000 : baud_len_ff + ONE16;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_serial_sel;
		@(posedge clk) disable iff (rst)
		(valid_address_qualifier && addr == SERIAL_ADDR) |=>
			(serial_select_lo_a && serial_select_hi_b && !serial_select_low_n);
	endproperty
	a_serial_sel: assert property (p_serial_sel) else $error("serial selects wrong");

	property p_page;
		@(posedge clk) disable iff (rst)
		!(valid_address_qualifier && addr[15:12] == PAGE_NIBBLE) |=>
			!(serial_select_lo_a || par0_select || par1_select || !sense_buf_en_n_0);
	endproperty
	a_page: assert property (p_page) else $error("select outside page");

	property p_rs;
		@(posedge clk) disable iff (rst)
		1'b1 |=> (serial_register_select == $past(addr[0]));
	endproperty
	a_rs: assert property (p_rs) else $error("serial register select wrong");

	property p_busclk;
		@(posedge clk) disable iff (rst)
		$rose(bus_enable_clk) |=> bus_enable_clk [*8];
	endproperty
	a_busclk: assert property (p_busclk) else $error("bus clock high too short");

	property p_par;
		@(posedge clk) disable iff (rst)
		(valid_address_qualifier && addr == PAR1_ADDR) |=> (par1_select && !par0_select);
	endproperty
	a_par: assert property (p_par) else $error("parallel select wrong");

	property p_rs_pair;
		@(posedge clk) disable iff (rst)
		1'b1 |=> (parallel_register_select_hi == $past(addr[1])
			&& parallel_register_select_lo != $past(addr[0]));
	endproperty
	a_rs_pair: assert property (p_rs_pair) else $error("parallel register select wrong");

	property p_sense;
		@(posedge clk) disable iff (rst)
		(valid_address_qualifier && addr == SENSE_ADDR) |=> (!sense_buf_en_n_0 && !sense_buf_en_n_1);
	endproperty
	a_sense: assert property (p_sense) else $error("sense enable not low");

	property p_idle;
		@(posedge clk) disable iff (rst)
		!valid_address_qualifier |=> (serial_select_low_n && sense_buf_en_n_1 && !par0_select);
	endproperty
	a_idle: assert property (p_idle) else $error("select while qualifier low");

	property p_bus_half;
		@(posedge clk) disable iff (rst)
		(bus_edge && bus_seen_ff) |-> (bus_len_ff == BUS_HALF_LAST);
	endproperty
	a_bus_half: assert property (p_bus_half) else $error("bus clock half period wrong");

	property p_baud_half;
		@(posedge clk) disable iff (rst)
		(baud_edge && baud_seen_ff) |-> (baud_len_ff == baud_lim_ref - ONE16);
	endproperty
	a_baud_half: assert property (p_baud_half) else $error("baud half period wrong");

	property p_mid_term;
		@(posedge clk) disable iff (rst)
		(addr[11:4] != SENSE_ADDR[11:4]) |=> (sense_buf_en_n_0 && sense_buf_en_n_1);
	endproperty
	a_mid_term: assert property (p_mid_term) else $error("sense enable without mid decode");

	property p_low_sel;
		@(posedge clk) disable iff (rst)
		!addr[2] |=> serial_select_low_n;
	endproperty
	a_low_sel: assert property (p_low_sel) else $error("serial low select without bit two");

	property p_hi_b;
		@(posedge clk) disable iff (rst)
		!addr[1] |=> !serial_select_hi_b;
	endproperty
	a_hi_b: assert property (p_hi_b) else $error("serial high select without bit one");

	property p_par0;
		@(posedge clk) disable iff (rst)
		(valid_address_qualifier && addr == PAR0_ADDR) |=> (par0_select && !par1_select);
	endproperty
	a_par0: assert property (p_par0) else $error("lower parallel select wrong");

	property p_sense_read;
		@(posedge clk) disable iff (rst)
		sense_data_oe |-> ($past(rd_wr) && $past(valid_address_qualifier));
	endproperty
	a_sense_read: assert property (p_sense_read) else $error("sense readback outside read");

	property p_idle_oe;
		@(posedge clk) disable iff (rst)
		!valid_address_qualifier |=> (!sense_data_oe && !par1_select && !serial_select_hi_b);
	endproperty
	a_idle_oe: assert property (p_idle_oe) else $error("output active while qualifier low");

	c_serial: cover property (@(posedge clk) serial_select_lo_a && serial_select_hi_b);
	c_par0:   cover property (@(posedge clk) par0_select);
	c_par1:   cover property (@(posedge clk) par1_select);
	c_sense:  cover property (@(posedge clk) sense_data_oe);
endmodule

/* File: verilog/iod_pkg.sv */
// Purpose: Constants for the I/O board address decoder
// Assumes: 16-bit processor address, 100 MHz system clock
// Notes:   Base addresses assume the board strapped at its lowest position
package iod_pkg;
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [3:0]  PAGE_NIBBLE      = 4'hf;
	localparam logic [15:0] SENSE_ADDR       = 16'hf003;
	localparam logic [15:0] SERIAL_ADDR      = 16'hf006;
	localparam logic [15:0] PAR0_ADDR        = 16'hf008;
	localparam logic [15:0] PAR1_ADDR        = 16'hf00c;
	localparam logic [15:0] SERIAL_MASK      = 16'hfffc;
	localparam logic [15:0] PAR_MASK         = 16'hfffc;
	localparam logic [15:0] SENSE_MASK       = 16'hffff;
	localparam logic [1:0]  PAR0_SEL         = 2'h2;
	localparam logic [1:0]  PAR1_SEL         = 2'h3;
	// ------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------
	localparam int          CLK_HZ           = 100000000;
	localparam int          BUS_CLK_HZ       = 500000;
	localparam int          BAUD_OVERSAMPLE  = 16;
	localparam int          BUS_HALF_CYC     = CLK_HZ / BUS_CLK_HZ / 2;
	localparam logic [7:0]  BUS_HALF_LAST    = 8'(BUS_HALF_CYC - 1);
	localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h0001;
	localparam logic [15:0] ONE16            = 16'h0001;
	localparam logic [7:0]  ZERO8            = 8'h00;
endpackage
